// *** logic/ds3_tx_alarm_override.sv ***
// Transmit alarm override: replaces or modifies bits of the outbound DS3 stream.
// Assumes the upstream framer tags each bit with its class and marks each M-frame start.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`include "ds3_tx_defs.svh"
`timescale 1ns/1ps
module ds3_tx_alarm_override
	import ds3_tx_pkg::*;
#(
	parameter int FIFO_DEPTH = 32
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wdata,
	input  wire logic        wr_en,
	input  wire logic        rd_en,
	output logic [7:0]       rdata,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic        in_bit,
	input  wire kind_t       in_kind,
	input  wire logic        in_frame_start,
	input  wire logic        rx_los,
	input  wire logic        rx_oof,
	input  wire logic        rx_ais,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic             out_bit,
	output kind_t            out_kind,
	output logic             out_frame_start
);
	localparam int WORD_W = 5;

	// The buffer wraps its binary pointers, so only powers of two are served.
	if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_depth_chk
		$error("FIFO depth must be a power of two of at least two.");
	end

	logic [7:0]        cfg_q;
	logic [2:0]        rx_s;
	logic [WORD_W-1:0] fifo_din;
	logic [WORD_W-1:0] fifo_dout;
	logic              fifo_valid;
	logic              take;
	logic              src_bit;
	kind_t             src_kind;
	logic              src_start;
	logic              auto_yellow;
	logic              yellow_any;
	mode_t             mode;
	logic              new_bit;
	logic [1:0]        pat_cnt_q;
	logic              par_acc_q;
	logic              par_last_q;
	logic              out_valid_q;

	// Receive conditions may come from the receive clock, so they are filtered.
	pin_sync #(
		.W(3)
	) u_rx_sync (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.async_in ({rx_los, rx_oof, rx_ais}),
		.sync_out (rx_s)
	);

	// The FIFO absorbs bursts from the source; a stalled line stalls the source.
	assign fifo_din = {in_frame_start, in_kind, in_bit};

	sync_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.wr_valid (in_valid),
		.wr_ready (in_ready),
		.wr_data  (fifo_din),
		.rd_valid (fifo_valid),
		.rd_ready (take),
		.rd_data  (fifo_dout)
	);

	assign take      = fifo_valid && (!out_valid_q || out_ready);
	assign src_bit   = fifo_dout[0];
	assign src_kind  = kind_t'(fifo_dout[3:1]);
	assign src_start = fifo_dout[4];

	// Register port.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cfg_q <= `CFG_RESET;
		end else if (wr_en && addr == `CFG_ADDR) begin
			cfg_q <= wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				`CFG_ADDR: begin
					rdata <= cfg_q;
				end
				`STAT_ADDR: begin
					rdata <= {2'h0, mode, rx_s};
				end
				default: begin
					rdata <= 8'h00;
				end
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// Automatic far-end receive failure from near-end receive conditions.
	assign auto_yellow = (cfg_q[`CFG_AUTO_LOS] && rx_s[2])
		|| (cfg_q[`CFG_AUTO_OOF] && rx_s[1])
		|| (cfg_q[`CFG_AUTO_AIS] && rx_s[0]);
	assign yellow_any = cfg_q[`CFG_YELLOW] || auto_yellow;

	// One mode is chosen per bit from the current settings.
	always_comb begin
		if (cfg_q[`CFG_LOS]) begin
			mode = M_LOS;
		end else if (cfg_q[`CFG_AIS]) begin
			mode = M_AIS;
		end else if (cfg_q[`CFG_IDLE]) begin
			mode = M_IDLE;
		end else if (yellow_any) begin
			mode = M_YELLOW;
		end else if (cfg_q[`CFG_XFORCE]) begin
			mode = M_XFORCE;
		end else begin
			mode = M_NORMAL;
		end
	end

	// Patterns keep running across modes, so a pattern may start at any phase.
	always_comb begin
		new_bit = src_bit;
		case (mode)
			M_LOS: begin
				new_bit = 1'b0;
			end
			M_AIS: begin
				case (src_kind)
					K_X:       new_bit = 1'b1;
					K_C, K_CP: new_bit = 1'b0;
					K_P:       new_bit = par_last_q;
					K_PAY:     new_bit = ~pat_cnt_q[0];
					default:   new_bit = src_bit;
				endcase
			end
			M_IDLE: begin
				case (src_kind)
					K_X:     new_bit = 1'b1;
					K_CP:    new_bit = 1'b0;
					K_P:     new_bit = par_last_q;
					K_PAY:   new_bit = ~pat_cnt_q[1];
					default: new_bit = src_bit;
				endcase
			end
			M_YELLOW: begin
				if (src_kind == K_X) begin
					new_bit = 1'b0;
				end
			end
			M_XFORCE: begin
				if (src_kind == K_X) begin
					new_bit = 1'b1;
				end
			end
			M_NORMAL: begin
				new_bit = src_bit;
			end
			default: begin
				new_bit = src_bit;
			end
		endcase
	end

	// Pattern phase advances on every payload bit sent.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			pat_cnt_q <= 2'h0;
		end else if (take && src_kind == K_PAY) begin
			pat_cnt_q <= pat_cnt_q + 2'h1;
		end
	end

	// In the AIS and idle patterns, P-bits carry the parity of the payload actually sent in the previous frame.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			par_acc_q  <= 1'b0;
			par_last_q <= 1'b0;
		end else if (take) begin
			if (src_start) begin
				par_last_q <= par_acc_q;
				par_acc_q  <= (src_kind == K_PAY) ? new_bit : 1'b0;
			end else if (src_kind == K_PAY) begin
				par_acc_q <= par_acc_q ^ new_bit;
			end
		end
	end

	// Output stage toward the line interface.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_valid_q <= 1'b0;
		end else if (take) begin
			out_valid_q <= 1'b1;
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_bit         <= 1'b0;
			out_kind        <= K_PAY;
			out_frame_start <= 1'b0;
		end else if (take) begin
			out_bit         <= new_bit;
			out_kind        <= src_kind;
			out_frame_start <= src_start;
		end
	end

	assign out_valid = out_valid_q;

	chk_los_all_zero : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && cfg_q[`CFG_LOS] |=> out_valid && !out_bit)
		else $error("LOS pattern sent a one.");

	chk_los_wins : assert property (@(posedge ref_clk) disable iff (!rst_b)
		cfg_q[`CFG_LOS] |-> mode == M_LOS)
		else $error("LOS pattern did not take precedence.");

	chk_ais_over_idle : assert property (@(posedge ref_clk) disable iff (!rst_b)
		cfg_q[`CFG_AIS] && cfg_q[`CFG_IDLE] && !cfg_q[`CFG_LOS] |-> mode == M_AIS)
		else $error("Idle pattern was not overridden by AIS.");

	chk_ais_c_zero : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_AIS && (src_kind == K_C || src_kind == K_CP)
		|=> !out_bit && (out_kind == K_C || out_kind == K_CP))
		else $error("AIS pattern sent a C-bit of one.");

	chk_ais_alternates : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_AIS && src_kind == K_PAY
		##1 take && mode == M_AIS && src_kind == K_PAY
		|=> out_bit != $past(out_bit))
		else $error("AIS payload did not alternate.");

	chk_idle_payload : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_IDLE && src_kind == K_PAY |=> out_bit == !$past(pat_cnt_q[1]))
		else $error("Idle payload left the 1100 sequence.");

	chk_idle_cp_zero : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_IDLE && src_kind == K_CP |=> !out_bit)
		else $error("Idle pattern sent a CP-bit of one.");

	chk_xforce_ones : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && cfg_q[`CFG_XFORCE] && !yellow_any && cfg_q[5:3] == 3'h0
		&& src_kind == K_X |=> out_bit)
		else $error("Forced X-bit was not one.");

	chk_xforce_ignored : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && cfg_q[`CFG_XFORCE] && cfg_q[`CFG_YELLOW] && cfg_q[5:3] == 3'h0
		&& src_kind == K_X |=> !out_bit)
		else $error("X-bit force beat the yellow alarm.");

	chk_auto_yellow : assert property (@(posedge ref_clk) disable iff (!rst_b)
		cfg_q[`CFG_AUTO_LOS] && rx_s[2] && cfg_q[5:3] == 3'h0 |-> mode == M_YELLOW)
		else $error("Receive loss of signal raised no yellow alarm.");

	chk_oof_yellow : assert property (@(posedge ref_clk) disable iff (!rst_b)
		cfg_q[`CFG_AUTO_OOF] && rx_s[1] && cfg_q[5:3] == 3'h0 |-> mode == M_YELLOW)
		else $error("Receive out-of-frame raised no yellow alarm.");

	chk_ais_yellow : assert property (@(posedge ref_clk) disable iff (!rst_b)
		cfg_q[`CFG_AUTO_AIS] && rx_s[0] && cfg_q[5:3] == 3'h0 |-> mode == M_YELLOW)
		else $error("Receive AIS raised no yellow alarm.");

	chk_payload_pass : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && cfg_q[5:3] == 3'h0 && src_kind == K_PAY |=> out_bit == $past(src_bit))
		else $error("Payload was modified without a pattern.");

	chk_cfg_read : assert property (@(posedge ref_clk) disable iff (!rst_b)
		rd_en && addr == `CFG_ADDR && !wr_en |=> rdata == $past(cfg_q))
		else $error("Configuration read back wrong.");

	chk_los_x_zero : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && cfg_q[`CFG_LOS] && src_kind == K_X |=> !out_bit)
		else $error("LOS pattern lost an X-bit to another override.");

	chk_ais_beats_idle : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && cfg_q[`CFG_AIS] && cfg_q[`CFG_IDLE] && !cfg_q[`CFG_LOS] && src_kind == K_C
		|=> !out_bit)
		else $error("Idle pattern passed a C-bit under AIS.");

	chk_idle_x_one : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_IDLE && src_kind == K_X |=> out_bit)
		else $error("Idle pattern sent an X-bit of zero.");

	chk_ais_x_one : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_AIS && src_kind == K_X |=> out_bit)
		else $error("AIS pattern sent an X-bit of zero.");

	chk_yellow_x_zero : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_YELLOW && src_kind == K_X |=> !out_bit)
		else $error("Yellow alarm sent an X-bit of one.");

	chk_yellow_keeps_payload : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_YELLOW && src_kind == K_PAY |=> out_bit == $past(src_bit))
		else $error("Yellow alarm modified the payload.");

	chk_xforce_keeps_payload : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_XFORCE && src_kind == K_PAY |=> out_bit == $past(src_bit))
		else $error("X-bit force modified the payload.");

	chk_normal_pass : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_NORMAL |=> out_bit == $past(src_bit))
		else $error("Normal operation altered a bit.");

	chk_no_auto_yellow : assert property (@(posedge ref_clk) disable iff (!rst_b)
		rx_s[2] && !cfg_q[`CFG_AUTO_LOS] && !cfg_q[`CFG_YELLOW] && cfg_q[5:3] == 3'h0
		&& !(cfg_q[`CFG_AUTO_OOF] && rx_s[1]) && !(cfg_q[`CFG_AUTO_AIS] && rx_s[0])
		|-> mode != M_YELLOW)
		else $error("Disabled loss of signal cause raised a yellow alarm.");

	chk_pattern_parity : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && (mode == M_AIS || mode == M_IDLE) && src_kind == K_P
		|=> out_bit == $past(par_last_q))
		else $error("Pattern P-bit did not carry the previous frame parity.");

	chk_out_holds : assert property (@(posedge ref_clk) disable iff (!rst_b)
		out_valid && !out_ready
		|=> out_valid && $stable(out_bit) && $stable(out_kind) && $stable(out_frame_start))
		else $error("Output bit changed while the line stalled.");

	chk_tags_kept : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take
		|=> out_valid && out_kind == $past(src_kind) && out_frame_start == $past(src_start))
		else $error("Bit class or frame start was not carried to the line.");

	chk_idle_c_pass : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && mode == M_IDLE && src_kind == K_C |=> out_bit == $past(src_bit))
		else $error("Idle pattern altered a C-bit outside F-frame three.");

	chk_mf_pass : assert property (@(posedge ref_clk) disable iff (!rst_b)
		take && (mode == M_AIS || mode == M_IDLE) && (src_kind == K_M || src_kind == K_F)
		|=> out_bit == $past(src_bit))
		else $error("Pattern did not keep the M and F bits.");

	chk_cfg_write : assert property (@(posedge ref_clk) disable iff (!rst_b)
		wr_en && addr == `CFG_ADDR |=> cfg_q == $past(wdata))
		else $error("Configuration write did not land.");

	chk_rdata_idle : assert property (@(posedge ref_clk) disable iff (!rst_b)
		!rd_en |=> rdata == 8'h00)
		else $error("Read data stood outside its cycle.");
endmodule

// *** logic/ds3_tx_defs.svh ***
// Register offsets, field positions and reset values of the transmit alarm override.
// Assumes an 8-bit register port; included by the design files by its bare name.
`ifndef DS3_TX_DEFS_SVH
`define DS3_TX_DEFS_SVH
`define CFG_ADDR        8'h30
`define STAT_ADDR       8'h31
`define CFG_RESET       8'h07
`define CFG_YELLOW      7
`define CFG_XFORCE      6
`define CFG_IDLE        5
`define CFG_AIS         4
`define CFG_LOS         3
`define CFG_AUTO_LOS    2
`define CFG_AUTO_OOF    1
`define CFG_AUTO_AIS    0
`define STAT_MODE_LSB   3
`define STAT_RX_LOS     2
`define STAT_RX_OOF     1
`define STAT_RX_AIS     0
`endif

// *** logic/ds3_tx_pkg.sv ***
// Types shared by the transmit alarm override.
// Assumes the upstream framer tags every bit with its position class.
package ds3_tx_pkg;
	typedef enum logic [2:0] {K_PAY, K_X, K_P, K_M, K_F, K_CP, K_C} kind_t;
	typedef enum logic [2:0] {M_NORMAL, M_XFORCE, M_YELLOW, M_IDLE, M_AIS, M_LOS} mode_t;
endpackage

// *** logic/sync_fifo.sv ***
// Single-clock FIFO with valid and ready on both sides.
// Assumes one clock; depth must be a power of two.
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 5,
	parameter int DEPTH = 32
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic             wr_valid,
	output logic                  wr_ready,
	input  wire logic [WIDTH-1:0] wr_data,
	output logic                  rd_valid,
	input  wire logic             rd_ready,
	output logic [WIDTH-1:0]      rd_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wptr_q;
	logic [AW-1:0]    rptr_q;
	logic [AW:0]      count_q;
	logic             push;
	logic             pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
		$error("FIFO depth must be a power of two of at least two.");
	end

	assign wr_ready = (count_q != DEPTH[AW:0]);
	assign rd_valid = (count_q != '0);
	assign push     = wr_valid && wr_ready;
	assign pop      = rd_valid && rd_ready;
	assign rd_data  = mem_q[rptr_q];

	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wptr_q] <= wr_data;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wptr_q <= wptr_q + 1'b1;
			end
			if (pop) begin
				rptr_q <= rptr_q + 1'b1;
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// *** logic/pin_sync.sv ***
// Three-stage synchroniser with agreement filter for asynchronous levels.
// A change is taken once the second and third stages agree.
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 3
) (
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] async_in,
	output logic [W-1:0]      sync_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_q     <= '0;
			s2_q     <= '0;
			s3_q     <= '0;
			sync_out <= '0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < W; i++) begin
				if (s2_q[i] == s3_q[i]) begin
					sync_out[i] <= s2_q[i];
				end
			end
		end
	end
endmodule

// *** tb/line_sink.sv ***
// Line-side partner: accepts outbound bits, stalling at random.
// Assumes one clock; hold keeps it stalled for fill tests.
`timescale 1ns/1ps
module line_sink (
	input  wire logic ref_clk,
	input  wire logic rst_b,
	input  wire logic hold,
	output logic      out_ready
);
	logic [7:0] lfsr_q;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lfsr_q    <= 8'h5a;
			out_ready <= 1'b0;
		end else begin
			lfsr_q    <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			out_ready <= !hold && (lfsr_q[1:0] != 2'h0);
		end
	end
endmodule

// *** tb/ds3_tx_alarm_override_tb_top.sv ***
// Self-checking bench of the transmit alarm override.
// Assumes line_sink as partner; the driver queues expected bits.
`timescale 1ns/1ps
module ds3_tx_alarm_override_tb_top;
	import ds3_tx_pkg::*;
	logic ref_clk = 0, rst_b = 0, wr_en = 0, rd_en = 0, in_valid = 0, in_bit = 0;
	logic in_frame_start = 0, rx_los = 0, rx_oof = 0, rx_ais = 0, hold = 0, rd_d = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cfg;
	logic in_ready, out_valid, out_ready, out_bit, out_frame_start, p1, p2, pa = 0, pl = 0;
	kind_t in_kind = K_PAY, out_kind;
	logic [6:0] sq[$];
	logic [7:0] rq[$];
	int fail_count = 0, n_tests = 0, npay;
	logic [31:0] seed = 32'h42b3fd41;
	logic [10:0] tbl [10] = '{11'h000, 11'h207, 11'h600, 11'h300, 11'h180,
		11'h7c7, 11'h224, 11'h012, 11'h009, 11'h01c};
	always #4 ref_clk = ~ref_clk;
	ds3_tx_alarm_override dut (.ref_clk(ref_clk), .rst_b(rst_b), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.in_valid(in_valid), .in_ready(in_ready), .in_bit(in_bit), .in_kind(in_kind),
		.in_frame_start(in_frame_start), .rx_los(rx_los), .rx_oof(rx_oof),
		.rx_ais(rx_ais), .out_valid(out_valid), .out_ready(out_ready),
		.out_bit(out_bit), .out_kind(out_kind), .out_frame_start(out_frame_start));
	line_sink partner (.ref_clk(ref_clk), .rst_b(rst_b), .hold(hold),
		.out_ready(out_ready));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [2:0] mode_of(logic [7:0] c);
		if (c[3]) return 3'h5;
		if (c[4]) return 3'h4;
		if (c[5]) return 3'h3;
		if (c[7] | (c[2] & rx_los) | (c[1] & rx_oof) | (c[0] & rx_ais)) return 3'h2;
		if (c[6]) return 3'h1;
		return 3'h0;
	endfunction
	// Codes: 0 or 1 exact, 2 skip, 3 inverse of last payload, 4 inverse of one before.
	// Code 5 is the payload parity of the previous frame.
	function automatic logic [2:0] exp_of(logic [2:0] m, kind_t k, logic b);
		case (m)
		3'h5: return 3'h0;
		3'h4: return k == K_X ? 3'h1 : (k == K_C || k == K_CP) ? 3'h0 :
			k == K_P ? 3'h5 : k == K_PAY ? 3'h3 : {2'h0, b};
		3'h3: return k == K_X ? 3'h1 : k == K_CP ? 3'h0 :
			k == K_P ? 3'h5 : k == K_PAY ? 3'h4 : {2'h0, b};
		3'h2: return k == K_X ? 3'h0 : {2'h0, b};
		3'h1: return k == K_X ? 3'h1 : {2'h0, b};
		default: return {2'h0, b};
		endcase
	endfunction
	task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
		n_tests++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic print_verdict();
		if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		wr_en <= 1;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
		wr_en <= 0;
		@(posedge ref_clk);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		rd_en <= 1;
		addr <= a;
		rq.push_back(e);
		@(posedge ref_clk);
		rd_en <= 0;
		@(posedge ref_clk);
	endtask
	// The phase of a pattern is free, so its first two payload bits are skipped.
	task automatic push(kind_t k, logic b);
		logic [2:0] c;
		c = exp_of(mode_of(cfg), k, b);
		if (c == 3'h3 || c == 3'h4) begin
			if (npay < 2) c = 3'h2;
			npay++;
		end
		sq.push_back({k == K_M && b, k, c});
		in_valid <= 1;
		in_kind <= k;
		in_bit <= b;
		in_frame_start <= k == K_M && b;
		#1;
		while (!in_ready) begin
			@(posedge ref_clk);
			#1;
		end
		@(posedge ref_clk);
	endtask
	task automatic drain();
		in_valid <= 0;
		for (int i = 0; i < 400 && sq.size() > 0; i++) @(posedge ref_clk);
		chk("queue", 8'(sq.size()), 8'h00);
	endtask
	always @(posedge ref_clk) begin
		logic [6:0] e;
		logic x;
		rd_d <= rd_en;
		if (rd_d) chk("rdata", rdata, rq.pop_front());
		if (!rst_b) begin
			pa = 1'b0;
			pl = 1'b0;
		end
		if (out_valid && out_ready && sq.size() == 0) chk("out_extra", 8'h01, 8'h00);
		if (out_valid && out_ready && sq.size() > 0) begin
			e = sq.pop_front();
			x = e[2:0] == 3'h3 ? !p1 : e[2:0] == 3'h4 ? !p2 : e[2:0] == 3'h5 ? pl : e[0];
			if (e[2:0] != 3'h2) chk("out_bit", {7'h0, out_bit}, {7'h0, x});
			chk("out_kind", {5'h0, out_kind}, {5'h0, e[5:3]});
			chk("out_frame_start", {7'h0, out_frame_start}, {7'h0, e[6]});
			if (out_kind == K_PAY) begin
				p2 = p1;
				p1 = out_bit;
			end
			if (out_frame_start) begin
				pl = pa;
				pa = out_kind == K_PAY && out_bit;
			end else if (out_kind == K_PAY) begin
				pa = pa ^ out_bit;
			end
		end
	end
	initial begin
		logic [31:0] r;
		repeat (5) @(posedge ref_clk);
		rst_b <= 1;
		@(posedge ref_clk);
		cfg = 8'h07;
		rd(8'h30, 8'h07);
		rd(8'h55, 8'h00);
		wr(8'h31, 8'hff);
		wr(8'h55, 8'hff);
		rd(8'h31, 8'h00);
		foreach (tbl[i]) begin
			{rx_los, rx_oof, rx_ais} <= tbl[i][2:0];
			cfg = tbl[i][10:3];
			wr(8'h30, cfg);
			repeat (6) @(posedge ref_clk);
			rd(8'h30, cfg);
			rd(8'h31, {2'h0, mode_of(cfg), rx_los, rx_oof, rx_ais});
			npay = 0;
			repeat (40) begin
				r = rnd();
				push(kind_t'(r[2:0] % 7), r[3]);
			end
			drain();
		end
		// Stalled line: 32 words in the buffer plus one in the output stage.
		hold <= 1;
		repeat (3) @(posedge ref_clk);
		repeat (33) push(K_PAY, 1'(rnd()));
		in_valid <= 0;
		#1;
		chk("in_ready", {7'h0, in_ready}, 8'h00);
		@(posedge ref_clk);
		hold <= 0;
		drain();
		// A second reset in mid-run must bring the register back to its default.
		rst_b <= 0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1;
		@(posedge ref_clk);
		rd(8'h30, 8'h07);
		repeat (2) @(posedge ref_clk);
		print_verdict();
	end
	initial begin
		#400000;
		fail_count++;
		print_verdict();
	end
endmodule
